/* src/pim_params.svh */
`ifndef PIM_PARAMS_SVH
`define PIM_PARAMS_SVH
`define PIM_LEVELS          4
`define PIM_SUM_MASK_BIT    11
`define PIM_MASK_OFF_BIT    15
`define PIM_SUM_RESET       4'h1
`define PIM_LVL_MASK_RESET  4'hf
`define PIM_NUM_UNITS       8
`define PIM_OFF_CTRL        12'h000
`define PIM_OFF_STATUS      12'h004
`define PIM_OFF_LVL_MASK    12'h008
`define PIM_OFF_SUM_MASK    12'h00c
`define PIM_OFF_GATES       12'h010
`define PIM_OFF_UNIT_LVL    12'h014
`define PIM_OFF_ACCEPT      12'h018
`endif

/* src/pim_pkg.sv */
package pim_pkg;
  typedef logic [1:0] pim_level_type;
  typedef enum logic [2:0] {
    PIM_OP_NONE,
    PIM_OP_TRAP,
    PIM_OP_MASK_OFF,
    PIM_OP_MASK_ON,
    PIM_OP_LOAD_BLOCK,
    PIM_OP_CLASS_INT,
    PIM_OP_WAIT,
    PIM_OP_RESUME
  } pim_op_type;
endpackage : pim_pkg

/* src/pim_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
// Picks the highest priority (lowest numbered) level among qualified requests.
module pim_arbiter
  import pim_pkg::*;
(
  input  wire logic [7:0]          req,
  input  wire logic [15:0]         unit_level,
  input  wire logic [3:0]          level_ok,
  output logic                     found,
  output pim_level_type            level,
  output logic [2:0]               unit
);
  always_comb begin
    found = 1'b0;
    level = 2'd0;
    unit  = 3'd0;
    for (int l = 3; l >= 0; l--) begin
      for (int u = 7; u >= 0; u--) begin
        if (req[u] && level_ok[l] && unit_level[2*u +: 2] == 2'(l)) begin
          found = 1'b1;
          level = 2'(l);
          unit  = 3'(u);
        end
      end
    end
  end
endmodule : pim_arbiter
`default_nettype wire

/* src/pim_core.sv */
// What this block does
// - Summary mask is bit 11 of active level
// - Mask zero blocks priority, power, console interrupts
// - Other class interrupts never blocked by mask
// - Supervisor trap clears active summary mask
// - Mask-off with bit 15 clears mask
// - Any class interrupt clears active mask
// - Load-level-block loads mask from bit 11
// - Reset: levels 1-3 cleared, level 0 set
// - Mask-on with bit 15 sets mask
// - Accepted interrupt sets new level's mask
// - Wait state uses last active level's mask
// - Four-bit level enable mask, one per level
// - Separate write and read mask instructions
// - Reset sets all level enable bits
// - Gates set only by setup command
// - Four preemptive levels, program-assigned per unit
// - Requests polled during transfers too
// - Masks never block program level switch
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pim_params.svh"
module pim_core
  import pim_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                bootstrap_program_load,
  input  wire logic [7:0]          unit_req_pin,
  input  wire logic                power_warn_pin,
  input  wire logic                console_pin,
  input  wire logic                other_class_pin,
  output logic                     prio_int_take,
  output logic [1:0]               prio_int_level,
  output logic [2:0]               prio_int_unit,
  output logic                     gated_class_take,
  output logic [1:0]               active_level_out,
  output logic                     sum_mask_out
);
  logic [3:0]          sum_mask_reg;
  logic [3:0]          lvl_mask_reg;
  logic [7:0]          gate_reg;
  logic [15:0]         unit_lvl_reg;
  pim_level_type       active_reg;
  logic                wait_reg;
  logic [15:0]         last_instr_reg;
  logic                boot_q1_reg;
  logic                boot_q2_reg;
  logic                boot_d_reg;
  logic [7:0]          req_q1_reg;
  logic [7:0]          req_q2_reg;
  logic [2:0]          cls_q1_reg;
  logic [2:0]          cls_q2_reg;
  logic                xfer_busy_reg;
  logic [31:0]         prdata_next;

  wire logic wr_en  = clk_en && psel && penable && pwrite;
  wire logic rd_en  = clk_en && psel && !penable && !pwrite;
  // Gated by the enable so a frozen block does not keep re-applying the reset
  wire logic boot_rise = clk_en && boot_q2_reg && !boot_d_reg;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // Control word: [2:0] op, [4:3] target level, [31:16] instruction/status word
  wire logic        ctrl_wr  = wr_en && addr_hit(paddr, `PIM_OFF_CTRL);
  pim_op_type       op;
  assign op = pim_op_type'(pwdata[2:0]);
  wire logic [1:0]  op_lvl   = pwdata[4:3];
  wire logic [15:0] op_word  = pwdata[31:16];

  // Summary mask seen by the arbiter, wait uses last active level
  wire logic cur_sum = sum_mask_reg[active_reg];

  logic          arb_found;
  pim_level_type arb_level;
  logic [2:0]    arb_unit;
  logic [3:0]    level_ok;

  always_comb begin
    for (int l = 0; l < 4; l++) begin
      // Preempt only toward higher priority, or from wait at any level
      level_ok[l] = lvl_mask_reg[l] && cur_sum &&
                    (wait_reg || 2'(l) < active_reg);
    end
  end

  pim_arbiter u_arb (
    .req        (req_q2_reg & gate_reg),
    .unit_level (unit_lvl_reg),
    .level_ok   (level_ok),
    .found      (arb_found),
    .level      (arb_level),
    .unit       (arb_unit)
  );

  // Polling does not look at the transfer-busy flag at all
  wire logic take_prio = clk_en && arb_found;
  wire logic take_gated_cls = clk_en && cur_sum && (cls_q2_reg[0] || cls_q2_reg[1]);
  wire logic take_other_cls = clk_en && cls_q2_reg[2];
  wire logic take_cls = take_gated_cls || take_other_cls;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q1_reg <= 1'b0;
      boot_q2_reg <= 1'b0;
      boot_d_reg  <= 1'b0;
      req_q1_reg  <= 8'h00;
      req_q2_reg  <= 8'h00;
      cls_q1_reg  <= 3'h0;
      cls_q2_reg  <= 3'h0;
    end else if (clk_en) begin
      boot_q1_reg <= bootstrap_program_load;
      boot_q2_reg <= boot_q1_reg;
      boot_d_reg  <= boot_q2_reg;
      req_q1_reg  <= unit_req_pin;
      req_q2_reg  <= req_q1_reg;
      cls_q1_reg  <= {other_class_pin, console_pin, power_warn_pin};
      cls_q2_reg  <= cls_q1_reg;
    end
  end

  // Summary masks, one per level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_mask_reg <= `PIM_SUM_RESET;
    end else if (boot_rise) begin
      sum_mask_reg <= `PIM_SUM_RESET;
    end else if (clk_en) begin
      // Class interrupt wins over a same-cycle priority accept
      if (take_prio && !take_cls) begin
        sum_mask_reg[arb_level] <= 1'b1;
      end
      if (take_cls) begin
        sum_mask_reg[active_reg] <= 1'b0;
      end else if (ctrl_wr) begin
        case (op)
          PIM_OP_TRAP:       sum_mask_reg[active_reg] <= 1'b0;
          PIM_OP_MASK_OFF: begin
            if (op_word[`PIM_MASK_OFF_BIT]) sum_mask_reg[active_reg] <= 1'b0;
          end
          PIM_OP_MASK_ON: begin
            if (op_word[`PIM_MASK_OFF_BIT]) sum_mask_reg[active_reg] <= 1'b1;
          end
          PIM_OP_LOAD_BLOCK: sum_mask_reg[op_lvl] <= op_word[`PIM_SUM_MASK_BIT];
          default: ;
        endcase
      end
    end
  end

  // Active level and wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 2'd0;
      wait_reg   <= 1'b0;
    end else if (boot_rise) begin
      active_reg <= 2'd0;
      wait_reg   <= 1'b0;
    end else if (clk_en) begin
      if (take_prio && !take_cls) begin
        active_reg <= arb_level;
        wait_reg   <= 1'b0;
      end else if (ctrl_wr) begin
        case (op)
          // Program switch ignores every mask
          PIM_OP_LOAD_BLOCK: if (op_lvl <= active_reg) active_reg <= op_lvl;
          PIM_OP_WAIT:       wait_reg <= 1'b1;
          PIM_OP_RESUME:     wait_reg <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // Level enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_mask_reg <= `PIM_LVL_MASK_RESET;
    end else if (boot_rise) begin
      lvl_mask_reg <= `PIM_LVL_MASK_RESET;
    end else if (wr_en && addr_hit(paddr, `PIM_OFF_LVL_MASK)) begin
      lvl_mask_reg <= pwdata[3:0];
    end
  end

  // Unit gates and levels, written only by the setup command path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg     <= 8'h00;
      unit_lvl_reg <= 16'h0000;
    end else if (wr_en && addr_hit(paddr, `PIM_OFF_GATES)) begin
      // Setup command: [2:0] unit, [4:3] level, [8] gate
      gate_reg[pwdata[2:0]]             <= pwdata[8];
      unit_lvl_reg[2*pwdata[2:0] +: 2]  <= pwdata[4:3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_instr_reg <= 16'h0000;
      xfer_busy_reg  <= 1'b0;
    end else if (ctrl_wr) begin
      last_instr_reg <= op_word;
      xfer_busy_reg  <= pwdata[5];
    end
  end

  always_comb begin
    prdata_next = 32'h0000_0000;
    if (addr_hit(paddr, `PIM_OFF_STATUS)) begin
      prdata_next = {26'h000_0000, xfer_busy_reg, wait_reg, cur_sum, 1'b0, active_reg};
    end else if (addr_hit(paddr, `PIM_OFF_LVL_MASK)) begin
      prdata_next = {28'h000_0000, lvl_mask_reg};
    end else if (addr_hit(paddr, `PIM_OFF_SUM_MASK)) begin
      prdata_next = {28'h000_0000, sum_mask_reg};
    end else if (addr_hit(paddr, `PIM_OFF_GATES)) begin
      prdata_next = {24'h00_0000, gate_reg};
    end else if (addr_hit(paddr, `PIM_OFF_UNIT_LVL)) begin
      prdata_next = {16'h0000, unit_lvl_reg};
    end else if (addr_hit(paddr, `PIM_OFF_CTRL)) begin
      prdata_next = {last_instr_reg, 16'h0000};
    end
  end

  wire logic mapped = addr_hit(paddr, `PIM_OFF_CTRL) || addr_hit(paddr, `PIM_OFF_STATUS) ||
                      addr_hit(paddr, `PIM_OFF_LVL_MASK) || addr_hit(paddr, `PIM_OFF_SUM_MASK) ||
                      addr_hit(paddr, `PIM_OFF_GATES) || addr_hit(paddr, `PIM_OFF_UNIT_LVL);

  // No wait state: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) prdata <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_int_take    <= 1'b0;
      prio_int_level   <= 2'd0;
      prio_int_unit    <= 3'd0;
      gated_class_take <= 1'b0;
      active_level_out <= 2'd0;
      sum_mask_out     <= 1'b1;
    end else if (clk_en) begin
      prio_int_take    <= take_prio && !take_cls;
      prio_int_level   <= arb_level;
      prio_int_unit    <= arb_unit;
      gated_class_take <= take_cls;
      active_level_out <= active_reg;
      sum_mask_out     <= cur_sum;
    end
  end
endmodule : pim_core
`default_nettype wire

/* sim/pim_core_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module pim_core_properties
  import pim_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        other_class_pin,
  input wire logic        prio_int_take,
  input wire logic        gated_class_take,
  input wire logic        sum_mask_out
);
  wire logic       ctrl_wr;
  wire logic [2:0] op;
  assign ctrl_wr = psel && penable && pwrite && paddr == 12'h000;
  assign op      = pwdata[2:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_one: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_trap_clears: assert property (ctrl_wr && op == 3'h1 |-> ##[1:3] !sum_mask_out)
    else $error("trap left mask set");
  chk_off_clears: assert property (ctrl_wr && op == 3'h2 && pwdata[31] |-> ##[1:3] !sum_mask_out)
    else $error("mask off failed");
  chk_on_sets: assert property (ctrl_wr && op == 3'h3 && pwdata[31] |-> ##[1:3] sum_mask_out)
    else $error("mask on failed");
  chk_class_taken: assert property ($rose(other_class_pin) |-> ##[1:5] gated_class_take)
    else $error("class request not taken");
  chk_class_clears: assert property (gated_class_take |-> ##[0:2] !sum_mask_out)
    else $error("class take left mask set");
  chk_take_sets: assert property (prio_int_take |-> ##[0:2] sum_mask_out)
    else $error("accept left mask clear");
  cov_take: cover property (prio_int_take);
  cov_class: cover property (gated_class_take);
  cov_err: cover property (pslverr);
endmodule : pim_core_properties
bind pim_core pim_core_properties chk_inst (.*);
`default_nettype wire

/* sim/pim_unit_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pim_unit_model
  import pim_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic        pready,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [7:0]  want,
  output logic [7:0]       unit_req_pin
);
  logic [7:0] gate_reg;
  // Units snoop the setup command, nothing else moves a gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg <= 8'h00;
    end else if (psel && penable && pwrite && pready && paddr == 12'h010) begin
      gate_reg[pwdata[2:0]] <= pwdata[8];
    end
  end
  assign unit_req_pin = want & gate_reg;
endmodule : pim_unit_model
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pim_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} pim_row_type;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic        bootstrap_program_load, power_warn_pin, console_pin, other_class_pin;
  logic        prio_int_take, gated_class_take, sum_mask_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  unit_req_pin, want;
  logic [1:0]  prio_int_level, active_level_out, tl;
  logic [2:0]  prio_int_unit, tu;
  int          bad_count, num_checks, takes, ctakes;
  pim_row_type rows [4] = '{'{12'h008, 32'h0000_000f, 1'h0}, '{12'h00c, 32'h0000_0001, 1'h0},
                            '{12'h004, 32'h0000_0008, 1'h0}, '{12'hffc, 32'h0000_0000, 1'h1}};
  pim_core DUT (.*);
  pim_unit_model unit_model (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic op(input logic [31:0] d);
    apb(1'h1, 12'h000, d);
    repeat (3) @(posedge pclk);
  endtask : op
  task automatic watch(input int n);
    takes  = 0;
    ctakes = 0;
    repeat (n) begin
      @(posedge pclk);
      if (prio_int_take === 1'h1) begin
        takes++;
        tu = prio_int_unit;
        tl = prio_int_level;
      end
      if (gated_class_take === 1'h1) ctakes++;
    end
  endtask : watch
  task automatic table_pass(input string t);
    foreach (rows[i]) begin
      apb(1'h0, rows[i].a, 32'h0000_0000);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, err});
      if (!rows[i].e) chk("read", rows[i].d, rd);
    end
    $display("test %s done", t);
  endtask : table_pass
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge pclk);
    bad_count++;
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, want} = '0;
    {bootstrap_program_load, power_warn_pin, console_pin, other_class_pin} = 4'h0;
    clk_en = 1'h1;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    table_pass("reset");
    apb(1'h1, 12'h008, 32'h0000_0005);
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk("lvl_mask", 32'h0000_0005, rd);
    want <= 8'h68;
    apb(1'h1, 12'h010, 32'h0000_0113);
    apb(1'h1, 12'h010, 32'h0000_010d);
    apb(1'h1, 12'h010, 32'h0000_001e);
    // Take pulse follows the write by one edge, so watch at once
    apb(1'h1, 12'h000, 32'h0000_0006);
    watch(12);
    chk("unit", 32'h0000_0003, {29'h0, tu});
    chk("plevel", 32'h0000_0002, {30'h0, tl});
    chk("takes", 32'h0000_0001, takes);
    chk("level", 32'h0000_0002, {30'h0, active_level_out});
    op(32'h0000_0020);
    apb(1'h1, 12'h008, 32'h0000_000f);
    watch(12);
    chk("unit", 32'h0000_0005, {29'h0, tu});
    chk("level", 32'h0000_0001, {30'h0, active_level_out});
    $display("test accept done");
    op(32'h0000_0001);
    chk("trap", 32'h0000_0000, {31'h0, sum_mask_out});
    op(32'h8000_0003);
    chk("on", 32'h0000_0001, {31'h0, sum_mask_out});
    op(32'h0000_0002);
    chk("off_nobit", 32'h0000_0001, {31'h0, sum_mask_out});
    op(32'h8000_0002);
    chk("off", 32'h0000_0000, {31'h0, sum_mask_out});
    power_warn_pin <= 1'h1;
    console_pin    <= 1'h1;
    watch(8);
    chk("blocked", 32'h0000_0000, ctakes);
    power_warn_pin <= 1'h0;
    watch(6);
    apb(1'h1, 12'h000, 32'h8000_0003);
    watch(8);
    chk("console", 32'h0000_0001, {31'h0, ctakes > 0});
    console_pin <= 1'h0;
    watch(6);
    chk("cls_clr", 32'h0000_0000, {31'h0, sum_mask_out});
    other_class_pin <= 1'h1;
    watch(8);
    chk("other", 32'h0000_0001, {31'h0, ctakes > 0});
    other_class_pin <= 1'h0;
    watch(6);
    op(32'h0800_000c);
    chk("load1", 32'h0000_0001, {31'h0, sum_mask_out});
    op(32'h0000_000c);
    chk("load0", 32'h0000_0000, {31'h0, sum_mask_out});
    $display("test masks done");
    apb(1'h1, 12'h008, 32'h0000_0000);
    bootstrap_program_load <= 1'h1;
    repeat (4) @(posedge pclk);
    bootstrap_program_load <= 1'h0;
    repeat (6) @(posedge pclk);
    table_pass("bootstrap");
    stop_test;
  end
endmodule : testbench
`default_nettype wire
